// [scp_pkg.sv]
// Package of constants and carriers for the short-circuit fault retry block
package scp_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLOCK_PERIOD_PS   = 4000;
  localparam int BLANK_TIMEOUT_NS  = 125;
  localparam int RELEASE_DELAY_NS  = 20;
  localparam int BLANK_TIMEOUT_CYC = (BLANK_TIMEOUT_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int RELEASE_DELAY_CYC = (RELEASE_DELAY_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int TIMER_W           = 6;

  // ==========================================================================
  // Fault counter
  // ==========================================================================
  localparam int          COUNT_W     = 3;
  localparam logic [2:0]  COUNT_ZERO  = 3'h0;
  localparam logic [2:0]  COUNT_FAULT = 3'h7;
  localparam logic [2:0]  COUNT_ONE   = 3'h1;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic cycle_start;
    logic high_on_request;
    logic switch_near_supply;
    logic overcurrent;
  } sense_in_t;

  typedef struct packed {
    logic high_side_gate_drive;
    logic rectifier_gate_drive;
  } gate_out_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h1,
    ST_BLANK    = 4'h2,
    ST_RELEASE  = 4'h4,
    ST_SENSE    = 4'h8
  } blank_state_t;

endpackage

// [input_sync.sv]
// Three-stage synchroniser for asynchronous inputs with agreement filter
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] raw,
  output var  logic [WIDTH-1:0] clean
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ==========================================================================
  // Per-bit synchroniser chain
  // ==========================================================================
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          clean[i]  <= 1'b0;
        end else begin
          stage1[i] <= raw[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin
            clean[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate

endmodule // input_sync
`default_nettype wire

// [short_circuit_fault_retry.sv]
// Blanking window, fault counter and retry sequencing for short-circuit protection
`timescale 1ns/10ps
`default_nettype none
module short_circuit_fault_retry
  import scp_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire scp_pkg::sense_in_t sense_in,
  output var  scp_pkg::gate_out_t gate_out,
  output var  logic               current_limit_sense_pulldown,
  output var  logic               detect_enable,
  output var  logic               fault_active,
  output var  logic               modulator_enable
);
  import scp_pkg::*;

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  sense_in_t sense;

  input_sync #(
    .WIDTH ($bits(sense_in_t))
  ) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .raw   (sense_in),
    .clean (sense)
  );

  logic cycle_start_d;
  logic near_d;
  wire  cycle_edge = sense.cycle_start & ~cycle_start_d;
  wire  near_edge  = sense.switch_near_supply & ~near_d;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cycle_start_d <= 1'b0;
      near_d        <= 1'b0;
    end else begin
      cycle_start_d <= sense.cycle_start;
      near_d        <= sense.switch_near_supply;
    end
  end

  // ==========================================================================
  // Blanking window state machine
  // ==========================================================================
  blank_state_t       state;
  blank_state_t       next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic               blank_used;
  wire                oc_hit = (state == ST_SENSE) & sense.overcurrent;

  localparam logic [TIMER_W-1:0] TIMEOUT_LAST = TIMER_W'(BLANK_TIMEOUT_CYC - 1);
  localparam logic [TIMER_W-1:0] RELEASE_LAST = TIMER_W'(RELEASE_DELAY_CYC - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO   = '0;
  localparam logic [TIMER_W-1:0] TIMER_STEP   = TIMER_W'(1);

  wire timed_out      = (timer >= TIMEOUT_LAST);
  wire release_done   = (timer >= RELEASE_LAST);

  always_comb begin
    next_state = state;
    next_timer = timer + TIMER_STEP;
    case (state)
      ST_IDLE: begin
        next_timer = TIMER_ZERO;
        if (sense.high_on_request && modulator_enable && !fault_active && !blank_used) begin
          next_state = ST_BLANK;
        end
      end
      ST_BLANK: begin
        if (near_edge || sense.switch_near_supply) begin
          next_state = ST_RELEASE;
          next_timer = TIMER_ZERO;
        end else if (timed_out) begin
          next_state = ST_SENSE;
          next_timer = TIMER_ZERO;
        end
      end
      ST_RELEASE: begin
        if (release_done) begin
          next_state = ST_SENSE;
          next_timer = TIMER_ZERO;
        end
      end
      ST_SENSE: begin
        next_timer = TIMER_ZERO;
        if (!sense.high_on_request || cycle_edge || oc_hit) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_timer = TIMER_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ==========================================================================
  // One blanking window per switching cycle
  // ==========================================================================
  wire start_blank = (state == ST_IDLE) & (next_state == ST_BLANK);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      blank_used <= 1'b0;
    end else if (start_blank) begin
      blank_used <= 1'b1;
    end else if (cycle_edge) begin
      blank_used <= 1'b0;
    end
  end

  // ==========================================================================
  // Pulse termination and cycle overcurrent record
  // ==========================================================================
  logic pulse_killed;
  logic cycle_had_oc;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pulse_killed <= 1'b0;
      cycle_had_oc <= 1'b0;
    end else if (cycle_edge) begin
      pulse_killed <= 1'b0;
      cycle_had_oc <= oc_hit;
    end else if (oc_hit) begin
      pulse_killed <= 1'b1;
      cycle_had_oc <= 1'b1;
    end
  end

  // ==========================================================================
  // Fault counter and retry sequencing
  // ==========================================================================
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic               next_fault;

  wire count_at_zero = (count == COUNT_ZERO);
  wire count_at_top  = (count == COUNT_FAULT);

  always_comb begin
    next_count = count;
    next_fault = fault_active;
    if (cycle_edge) begin
      if (fault_active) begin
        if (!count_at_zero) begin
          next_count = count - COUNT_ONE;
        end
        if (count == COUNT_ONE || count_at_zero) begin
          next_fault = 1'b0;
        end
      end else if (cycle_had_oc || oc_hit) begin
        if (!count_at_top) begin
          next_count = count + COUNT_ONE;
        end
        if (count == (COUNT_FAULT - COUNT_ONE) || count_at_top) begin
          next_fault = 1'b1;
        end
      end else if (!count_at_zero) begin
        next_count = count - COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count        <= '0;
      fault_active <= 1'b0;
    end else begin
      count        <= next_count;
      fault_active <= next_fault;
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  wire drive_allowed = ~fault_active & ~next_fault;
  wire next_high     = drive_allowed & sense.high_on_request & ~pulse_killed & ~oc_hit
                       & (state != ST_IDLE);
  wire next_rect     = drive_allowed & ~sense.high_on_request & ~cycle_edge;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_out                     <= '0;
      current_limit_sense_pulldown <= 1'b0;
      detect_enable                <= 1'b0;
      modulator_enable             <= 1'b0;
    end else begin
      gate_out.high_side_gate_drive <= next_high;
      gate_out.rectifier_gate_drive <= next_rect;
      current_limit_sense_pulldown  <= (next_state == ST_BLANK) | (next_state == ST_RELEASE);
      detect_enable                 <= (next_state == ST_SENSE);
      modulator_enable              <= ~next_fault;
    end
  end

endmodule // short_circuit_fault_retry
`default_nettype wire

// [fault_retry_properties.sv]
// Port-level checks for the short-circuit fault retry block
`timescale 1ns/10ps
`default_nettype none
module fault_retry_properties
  import scp_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire scp_pkg::sense_in_t sense_in,
  input  wire scp_pkg::gate_out_t gate_out,
  input  wire logic               current_limit_sense_pulldown,
  input  wire logic               detect_enable,
  input  wire logic               fault_active,
  input  wire logic               modulator_enable
);
  // ==========================================================================
  // Blanking, cut-off and retry
  // ==========================================================================
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic pd;
  logic hs;
  assign pd = current_limit_sense_pulldown;
  assign hs = gate_out.high_side_gate_drive;
  a_blank_time_limit: assert property ($rose(pd) |-> ##[1:32] !pd)
    else $error("blanking overran its timeout");
  a_release_on_near: assert property ((pd && sense_in.switch_near_supply) [*8] |-> ##[0:6] !pd)
    else $error("blanking held after switch node neared supply");
  a_release_delay: assert property (pd && $rose(sense_in.switch_near_supply) |=> pd [*5])
    else $error("blanking released too early");
  a_no_detect_blank: assert property (pd |-> !detect_enable)
    else $error("detection enabled during blanking");
  a_detect_after_blank: assert property ($rose(detect_enable) |-> $past(pd) || $past(pd, 2))
    else $error("detection enabled without a blanking end");
  a_oc_cuts_pulse: assert property (sense_in.overcurrent && detect_enable && hs |-> ##[1:6] !hs)
    else $error("overcurrent did not end the pulse");
  a_off_till_cycle: assert property ($fell(hs) |=> !hs [*8])
    else $error("high side came back within the cycle");
  a_fault_gates_off: assert property (fault_active && $past(fault_active) |-> gate_out == 2'h0)
    else $error("gate drive active during fault");
  a_fault_mod_off: assert property (fault_active && $past(fault_active) |-> !modulator_enable)
    else $error("modulator enabled during fault");
  a_blank_needs_mod: assert property ($rose(pd) |-> modulator_enable && !fault_active && sense_in.high_on_request)
    else $error("blanking began without an on request");
  a_restart_enables: assert property ($fell(fault_active) |-> ##[0:2] modulator_enable)
    else $error("modulator not enabled after recovery");
endmodule // fault_retry_properties
bind short_circuit_fault_retry fault_retry_properties fault_retry_properties_inst (
  .clock, .nrst, .sense_in, .gate_out, .current_limit_sense_pulldown,
  .detect_enable, .fault_active, .modulator_enable);
`default_nettype wire

// [power_stage_model.sv]
// Behavioural power stage and comparators facing the gate drives
`timescale 1ns/10ps
`default_nettype none
module power_stage_model
  import scp_pkg::*;
(
  input  wire logic               clock,
  input  wire scp_pkg::gate_out_t gate,
  input  wire logic               slow,
  input  wire logic               short_load,
  output var  logic               near,
  output var  logic               oc
);
  // ==========================================================================
  // Switch node and overcurrent comparators
  // ==========================================================================
  logic [3:0] on_cnt;
  logic       hs;
  assign hs = gate.high_side_gate_drive;
  initial begin
    on_cnt = 4'h0;
    near = 1'b0;
    oc = 1'b0;
  end
  // Slow stage never brings the switch node near the supply
  always @(negedge clock) begin
    on_cnt <= hs ? on_cnt + {3'h0, on_cnt != 4'hF} : 4'h0;
    near <= hs && !slow && on_cnt >= 4'h3;
    oc <= hs && short_load && on_cnt >= 4'h3;
  end
endmodule // power_stage_model
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the short-circuit fault retry block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import scp_pkg::*;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic        clock, nrst, cs, req, slow, short_load, near, oc, last_fault, last_pd;
  logic        current_limit_sense_pulldown, detect_enable, fault_active, modulator_enable;
  gate_out_t   gate_out;
  sense_in_t   sense_in;
  int          error_cnt, total_checks, cyc, tick, blen;
  int          fq[$], bq[$];
  logic [31:0] rnd;
  assign sense_in = sense_in_t'({cs, req, near, oc});
  short_circuit_fault_retry short_circuit_fault_retry_inst (.clock, .nrst, .sense_in,
    .gate_out, .current_limit_sense_pulldown, .detect_enable, .fault_active, .modulator_enable);
  power_stage_model power_stage_model_inst (.clock, .gate(gate_out), .slow, .short_load,
    .near, .oc);
  initial clock = 1'b0;
  always #2 clock = ~clock;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One switching cycle with a random on-time
  task automatic run_cycle(input int base);
    rnd = lfsr_next(rnd);
    cs = 1'b1;
    cyc++;
    repeat (6) @(negedge clock);
    cs = 1'b0;
    repeat (6) @(negedge clock);
    req = 1'b1;
    repeat (base + int'(rnd[3:0])) @(negedge clock);
    req = 1'b0;
    repeat (10) @(negedge clock);
  endtask
  // ==========================================================================
  // Monitor and timeout
  // ==========================================================================
  always @(negedge clock) begin
    if (fault_active !== last_fault)
      chk(32'(cyc * 2) + 32'(fault_active), fq.size() > 0 ? 32'(fq.pop_front()) : 32'hFFFFFFFF);
    if (last_pd && !current_limit_sense_pulldown && bq.size() > 0)
      chk(32'(blen), 32'(bq.pop_front()));
    blen = current_limit_sense_pulldown ? blen + 1 : 0;
    last_pd = current_limit_sense_pulldown;
    last_fault = fault_active;
  end
  always @(posedge clock) begin
    tick++;
    if (tick == 6000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {nrst, cs, req, slow, short_load, last_fault, last_pd} = 7'h00;
    {error_cnt, total_checks, cyc, tick, blen} = 0;
    rnd = 32'h0001542A;
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    repeat (3) run_cycle(24);
    short_load = 1'b1;
    repeat (6) run_cycle(24);
    short_load = 1'b0;
    run_cycle(24);
    short_load = 1'b1;
    fq = '{(cyc + 3) * 2 + 1, (cyc + 10) * 2, (cyc + 17) * 2 + 1, (cyc + 24) * 2};
    repeat (17) run_cycle(24);
    short_load = 1'b0;
    repeat (9) run_cycle(24);
    chk(32'(fq.size()), 32'h0);
    $display("fault sequence done");
    slow = 1'b1;
    repeat (2) begin
      bq.push_back(BLANK_TIMEOUT_CYC);
      run_cycle(48);
    end
    chk(32'(bq.size()), 32'h0);
    $display("timeout sequence done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
